// ==== cei_event_interrupt_unit.sv ====
// CAN event interrupt unit: event flags, enable mask, receive-ready bits, interrupt output
`timescale 1ns/10ps
module cei_event_interrupt_unit
    import cei_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic regWr,
    input wire logic [7:0] regWrData,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic rxStoredPulse,
    input wire logic [3:0] rxObjIdx,
    input wire logic txDonePulse,
    input wire logic remoteFramePulse,
    input wire logic wakeupPulse,
    input wire logic busOffEnterPulse,
    input wire logic [7:0] recErrCnt,
    input wire logic [7:0] txErrCnt,
    input wire logic txCheckEnable,
    input wire logic txCheckErrPulse,
    input wire logic txCheckClear,
    input wire logic bitTick,
    output logic busOffRequest,
    output logic intOut
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic [15:0] rxReady_ff;
    logic [15:0] nxt_rxReady;
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;
    logic [2:0] tchkCnt_ff;
    logic [2:0] nxt_tchkCnt;
    logic warnPrev_ff;
    logic nxt_warnPrev;
    logic passPrev_ff;
    logic nxt_passPrev;
    logic intOut_ff;
    logic nxt_intOut;
    logic [7:0] setEv;
    logic [7:0] clrEv;
    logic [15:0] rrSet;
    logic [15:0] rrClr;
    logic warnNow;
    logic passNow;
    logic tcLimitHit;
    logic pending;
    logic wrFlags;
    logic wrMask;

    cei_hold_if hif ();

    cei_hold_timer u_hold (
        .ref_clk(ref_clk),
        .reset(reset),
        .hif(hif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Event detection
    always_comb begin
        warnNow = (recErrCnt >= CEI_WARN_LEVEL) || (txErrCnt >= CEI_WARN_LEVEL);
        passNow = (recErrCnt >= CEI_PASSIVE_LEVEL) || (txErrCnt >= CEI_PASSIVE_LEVEL);
        tcLimitHit = txCheckEnable && txCheckErrPulse && (tchkCnt_ff == CEI_TCHK_LIMIT - 3'h1);
        nxt_warnPrev = warnNow;
        nxt_passPrev = passNow;
        nxt_tchkCnt = tchkCnt_ff;
        if (txCheckClear) begin
            nxt_tchkCnt = CEI_TCHK_CNT_RESET;
        end else if (txCheckEnable && txCheckErrPulse && (tchkCnt_ff != CEI_TCHK_LIMIT)) begin
            nxt_tchkCnt = tchkCnt_ff + 3'h1;
        end
        setEv = 8'h00;
        setEv[CEI_BIT_RX] = rxStoredPulse;
        setEv[CEI_BIT_TX] = txDonePulse;
        setEv[CEI_BIT_WARN] = warnNow && !warnPrev_ff;
        setEv[CEI_BIT_REMOTE] = remoteFramePulse;
        setEv[CEI_BIT_WAKE] = wakeupPulse;
        setEv[CEI_BIT_BUSOFF] = busOffEnterPulse || tcLimitHit;
        setEv[CEI_BIT_PASSIVE] = passNow && !passPrev_ff;
        setEv[CEI_BIT_TCHK] = tcLimitHit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes: flags and ready bits clear on zero (receive flag only while no ready bit is set), set wins
    always_comb begin
        wrFlags = regWr && (regAddr == CEI_ADDR_FLAGS);
        wrMask = regWr && (regAddr == CEI_ADDR_MASK);
        clrEv = wrFlags ? ~regWrData : 8'h00;
        if (|rxReady_ff) begin
            clrEv[CEI_BIT_RX] = 1'b0;
        end
        rrSet = 16'h0000;
        rrSet[rxObjIdx] = rxStoredPulse;
        rrClr = 16'h0000;
        if (regWr && (regAddr == CEI_ADDR_RR_LOW)) begin
            rrClr[7:0] = ~regWrData;
        end
        if (regWr && (regAddr == CEI_ADDR_RR_HIGH)) begin
            rrClr[15:8] = ~regWrData;
        end
        nxt_rxReady = (rxReady_ff & ~rrClr) | rrSet;
        nxt_flags = (flags_ff & ~clrEv) | setEv;
        nxt_mask = wrMask ? regWrData : mask_ff;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, answered one cycle after the read strobe
    always_comb begin
        nxt_rdData = rdData_ff;
        if (regRd) begin
            unique case (regAddr)
                CEI_ADDR_RR_LOW: nxt_rdData = rxReady_ff[7:0];
                CEI_ADDR_RR_HIGH: nxt_rdData = rxReady_ff[15:8];
                CEI_ADDR_MASK: nxt_rdData = mask_ff;
                CEI_ADDR_FLAGS: nxt_rdData = flags_ff;
                default: nxt_rdData = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt output with minimum active time
    always_comb begin
        pending = |(flags_ff & mask_ff);
        hif.start = !intOut_ff && pending;
        hif.bitTick = bitTick;
        nxt_intOut = pending || (intOut_ff && hif.held);
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_ff <= CEI_FLAGS_RESET;
            mask_ff <= CEI_MASK_RESET;
            rxReady_ff <= CEI_RR_RESET;
            rdData_ff <= CEI_RDATA_RESET;
            tchkCnt_ff <= CEI_TCHK_CNT_RESET;
            warnPrev_ff <= 1'b0;
            passPrev_ff <= 1'b0;
            intOut_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            mask_ff <= nxt_mask;
            rxReady_ff <= nxt_rxReady;
            rdData_ff <= nxt_rdData;
            tchkCnt_ff <= nxt_tchkCnt;
            warnPrev_ff <= nxt_warnPrev;
            passPrev_ff <= nxt_passPrev;
            intOut_ff <= nxt_intOut;
        end
    end

    assign regRdData = rdData_ff;
    assign intOut = intOut_ff;
    assign busOffRequest = (tchkCnt_ff == CEI_TCHK_LIMIT);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_tc_limit;
        txCheckEnable && txCheckErrPulse && !txCheckClear ##0 tchkCnt_ff == CEI_TCHK_LIMIT - 3'h1;
    endsequence
    sequence s_bus_off_raised;
        flags_ff[CEI_BIT_BUSOFF] && flags_ff[CEI_BIT_TCHK] && busOffRequest;
    endsequence

    property p_rx_set;
        rxStoredPulse |=> flags_ff[CEI_BIT_RX] && rxReady_ff[$past(rxObjIdx)];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive flag not set");
    property p_rx_hold;
        flags_ff[CEI_BIT_RX] && (|rxReady_ff) |=> flags_ff[CEI_BIT_RX];
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("receive flag cleared early");
    property p_tx_set;
        txDonePulse |=> flags_ff[CEI_BIT_TX];
    endproperty
    a_tx_set: assert property (p_tx_set) else $error("transmit flag not set");
    property p_warn_set;
        $rose(recErrCnt >= CEI_WARN_LEVEL || txErrCnt >= CEI_WARN_LEVEL) |=> flags_ff[CEI_BIT_WARN];
    endproperty
    a_warn_set: assert property (p_warn_set) else $error("warning flag not set");
    property p_passive_set;
        $rose(recErrCnt >= CEI_PASSIVE_LEVEL || txErrCnt >= CEI_PASSIVE_LEVEL) |=> flags_ff[CEI_BIT_PASSIVE];
    endproperty
    a_passive_set: assert property (p_passive_set) else $error("passive flag not set");
    property p_tc_limit;
        s_tc_limit |=> s_bus_off_raised;
    endproperty
    a_tc_limit: assert property (p_tc_limit) else $error("check limit missed");
    property p_no_write_set;
        wrFlags && (setEv == 8'h00) |=> (flags_ff & ~$past(flags_ff)) == 8'h00;
    endproperty
    a_no_write_set: assert property (p_no_write_set) else $error("write set a flag");
    property p_mask_gate;
        $rose(intOut) |-> $past(|(flags_ff & mask_ff));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("output raised by masked flag");
    property p_min_active;
        $rose(intOut) |-> intOut[*2] ##0 hif.held;
    endproperty
    a_min_active: assert property (p_min_active) else $error("output dropped too soon");
    property p_drop;
        intOut && !pending && !hif.held |=> !intOut;
    endproperty
    a_drop: assert property (p_drop) else $error("output stuck");
    property p_mask_write;
        wrMask && (setEv == 8'h00) |=> $stable(flags_ff);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write changed flags");
endmodule

// ==== cei_pkg.sv ====
// Constants shared by the CAN event interrupt unit and its hold timer
package cei_pkg;
    // Register addresses on the internal register port
    localparam logic [7:0] CEI_ADDR_RR_LOW = 8'h04;
    localparam logic [7:0] CEI_ADDR_RR_HIGH = 8'h05;
    localparam logic [7:0] CEI_ADDR_MASK = 8'h0a;
    localparam logic [7:0] CEI_ADDR_FLAGS = 8'h11;
    // Reset values
    localparam logic [7:0] CEI_FLAGS_RESET = 8'h00;
    localparam logic [7:0] CEI_MASK_RESET = 8'h00;
    localparam logic [15:0] CEI_RR_RESET = 16'h0000;
    localparam logic [7:0] CEI_RDATA_RESET = 8'h00;
    // Flag and enable bit positions
    localparam int CEI_BIT_RX = 0;
    localparam int CEI_BIT_TX = 1;
    localparam int CEI_BIT_WARN = 2;
    localparam int CEI_BIT_REMOTE = 3;
    localparam int CEI_BIT_WAKE = 4;
    localparam int CEI_BIT_BUSOFF = 5;
    localparam int CEI_BIT_PASSIVE = 6;
    localparam int CEI_BIT_TCHK = 7;
    // Error counter thresholds
    localparam logic [7:0] CEI_WARN_LEVEL = 8'h60;
    localparam logic [7:0] CEI_PASSIVE_LEVEL = 8'h80;
    localparam logic [2:0] CEI_TCHK_LIMIT = 3'h4;
    localparam logic [2:0] CEI_TCHK_CNT_RESET = 3'h0;
    // Interrupt hold: bit ticks to see so a full bit time has elapsed
    localparam logic [1:0] CEI_MIN_ACTIVE_BITS = 2'h1;
    localparam logic [1:0] CEI_HOLD_TICKS = CEI_MIN_ACTIVE_BITS + 2'h1;
    localparam logic [1:0] CEI_HOLD_RESET = 2'h0;
    // Hold timer states
    typedef enum logic {
        CEI_T_IDLE = 1'b0,
        CEI_T_RUN = 1'b1
    } cei_hold_state_t;
endpackage

// ==== cei_hold_if.sv ====
// Link between the interrupt unit and its minimum-active hold timer
`timescale 1ns/10ps
interface cei_hold_if;
    logic start;
    logic bitTick;
    logic held;
    modport unit (output start, output bitTick, input held);
    modport timer (input start, input bitTick, output held);
endinterface

// ==== cei_hold_timer.sv ====
// Hold timer that keeps the interrupt output up for at least one bit time
`timescale 1ns/10ps
module cei_hold_timer
    import cei_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    cei_hold_if.timer hif
);
    cei_hold_state_t state_ff;
    cei_hold_state_t nxt_state;
    logic [1:0] tickCnt_ff;
    logic [1:0] nxt_tickCnt;

    // Restart on each new assertion, count bit ticks until a full bit passed
    always_comb begin
        nxt_state = state_ff;
        nxt_tickCnt = tickCnt_ff;
        if (hif.start) begin
            nxt_state = CEI_T_RUN;
            nxt_tickCnt = CEI_HOLD_RESET;
        end else begin
            unique case (state_ff)
                CEI_T_IDLE: begin
                    nxt_tickCnt = CEI_HOLD_RESET;
                end
                CEI_T_RUN: begin
                    if (hif.bitTick) begin
                        nxt_tickCnt = tickCnt_ff + 2'h1;
                        if (tickCnt_ff + 2'h1 == CEI_HOLD_TICKS) begin
                            nxt_state = CEI_T_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff <= CEI_T_IDLE;
            tickCnt_ff <= CEI_HOLD_RESET;
        end else begin
            state_ff <= nxt_state;
            tickCnt_ff <= nxt_tickCnt;
        end
    end

    assign hif.held = (state_ff == CEI_T_RUN);

    // Hold ends only after the required number of bit ticks
    property p_hold_ticks;
        @(posedge ref_clk) disable iff (reset)
        $fell(hif.held) |-> $past(hif.bitTick) && ($past(tickCnt_ff) == CEI_HOLD_TICKS - 2'h1);
    endproperty
    a_hold_ticks: assert property (p_hold_ticks) else $error("hold ended early");
endmodule

// ==== cei_host_model.sv ====
// Host model: register strobes for the event interrupt unit
`timescale 1ns/10ps
module cei_host_model
    import cei_pkg::*;
(
    input wire logic ref_clk,
    output logic [7:0] regAddr,
    output logic regWr,
    output logic [7:0] regWrData,
    output logic regRd,
    input wire logic [7:0] regRdData
);
    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWr = 1'b0;
        regWrData = 8'h00;
        regRd = 1'b0;
    end
    // One-cycle write; released lines show inverse of last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regWrData = d;
        regWr = 1'b1;
        @(negedge ref_clk);
        regWr = 1'b0;
        regWrData = ~d;
        regAddr = ~a;
    endtask
    // One-cycle read; data registered at the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        regAddr = a;
        regRd = 1'b1;
        @(negedge ref_clk);
        regRd = 1'b0;
        regAddr = ~a;
        d = regRdData;
    endtask
endmodule

// ==== cei_event_interrupt_unit_tb.sv ====
// Self-checking testbench of the CAN event interrupt unit
`timescale 1ns/10ps
module cei_event_interrupt_unit_tb;
    import cei_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1;
    logic [7:0] regAddr, regWrData, regRdData, recErrCnt = 8'h00, txErrCnt = 8'h00;
    logic regWr, regRd, rxStoredPulse = 1'b0, txDonePulse = 1'b0, remoteFramePulse = 1'b0;
    logic wakeupPulse = 1'b0, busOffEnterPulse = 1'b0, txCheckEnable = 1'b0, txCheckErrPulse = 1'b0;
    logic txCheckClear = 1'b0, bitTick = 1'b0, busOffRequest, intOut;
    logic [3:0] rxObjIdx = 4'h0;
    int bad_count = 0, check_count = 0;
    cei_event_interrupt_unit cei_event_interrupt_unit_inst (.ref_clk(ref_clk), .reset(reset),
        .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
        .rxStoredPulse(rxStoredPulse), .rxObjIdx(rxObjIdx), .txDonePulse(txDonePulse),
        .remoteFramePulse(remoteFramePulse), .wakeupPulse(wakeupPulse), .busOffEnterPulse(busOffEnterPulse),
        .recErrCnt(recErrCnt), .txErrCnt(txErrCnt), .txCheckEnable(txCheckEnable),
        .txCheckErrPulse(txCheckErrPulse), .txCheckClear(txCheckClear), .bitTick(bitTick),
        .busOffRequest(busOffRequest), .intOut(intOut));
    cei_host_model cei_host_model_inst (.ref_clk(ref_clk), .regAddr(regAddr), .regWr(regWr),
        .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData));
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string m);
        logic [7:0] d;
        cei_host_model_inst.rd(a, d);
        chk(d, exp, m);
    endtask
    // One-cycle pulse on a source selected by flag position; 6 is the transmit check error, 7 is the bit tick
    task automatic evt(input int b);
        @(negedge ref_clk);
        case (b)
            0: rxStoredPulse = 1'b1;
            1: txDonePulse = 1'b1;
            3: remoteFramePulse = 1'b1;
            4: wakeupPulse = 1'b1;
            5: busOffEnterPulse = 1'b1;
            6: txCheckErrPulse = 1'b1;
            default: bitTick = 1'b1;
        endcase
        @(negedge ref_clk);
        {rxStoredPulse, txDonePulse, remoteFramePulse, wakeupPulse, busOffEnterPulse} = 5'h00;
        {txCheckErrPulse, bitTick} = 2'h0;
    endtask
    // Bounded wait for the interrupt output to rise
    task automatic wait_int();
        int i;
        for (i = 0; i < 8 && intOut !== 1'b1; i++) @(negedge ref_clk);
        if (intOut !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t interrupt output never rose", $time);
            results();
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rdchk(CEI_ADDR_MASK, CEI_MASK_RESET, "mask reset");
        rdchk(CEI_ADDR_FLAGS, CEI_FLAGS_RESET, "flags reset");
        rdchk(CEI_ADDR_RR_LOW, 8'h00, "ready reset");
        cei_host_model_inst.wr(8'h33, 8'hFF);
        rdchk(8'h33, 8'h00, "unmapped read");
        chk({7'h00, intOut}, 8'h00, "intOut reset");
        $display("t_reset done");
    endtask
    task automatic t_events();
        logic [7:0] exp;
        int srcs[4] = '{1, 3, 4, 5};
        exp = 8'h00;
        foreach (srcs[i]) begin
            evt(srcs[i]);
            exp[srcs[i]] = 1'b1;
            rdchk(CEI_ADDR_FLAGS, exp, "event flag");
        end
        cyc(3);
        chk({7'h00, intOut}, 8'h00, "masked flags raised intOut");
        cei_host_model_inst.wr(CEI_ADDR_MASK, 8'h01);
        cyc(3);
        chk({7'h00, intOut}, 8'h00, "other enable raised intOut");
        rdchk(CEI_ADDR_FLAGS, exp, "mask write touched flags");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'hFF);
        rdchk(CEI_ADDR_FLAGS, exp, "write one changed flags");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'hFD);
        rdchk(CEI_ADDR_FLAGS, exp & 8'hFD, "clear one flag");
        cyc(2);
        chk(regRdData, exp & 8'hFD, "read data not held");
        fork
            cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
            evt(1);
        join
        rdchk(CEI_ADDR_FLAGS, 8'h02, "event lost to clear");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        cei_host_model_inst.wr(CEI_ADDR_MASK, 8'h00);
        $display("t_events done");
    endtask
    task automatic t_levels();
        @(negedge ref_clk) recErrCnt = 8'h5F;
        rdchk(CEI_ADDR_FLAGS, 8'h00, "warning below 96");
        @(negedge ref_clk) recErrCnt = 8'h60;
        rdchk(CEI_ADDR_FLAGS, 8'h04, "warning at 96");
        recErrCnt = 8'h00;
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        @(negedge ref_clk) txErrCnt = 8'h80;
        rdchk(CEI_ADDR_FLAGS, 8'h44, "passive at 128");
        txErrCnt = 8'h00;
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        $display("t_levels done");
    endtask
    task automatic t_rx();
        rxObjIdx = 4'h2;
        evt(0);
        rxObjIdx = 4'h9;
        evt(0);
        rdchk(CEI_ADDR_RR_LOW, 8'h04, "ready bit 2");
        rdchk(CEI_ADDR_RR_HIGH, 8'h02, "ready bit 9");
        rdchk(CEI_ADDR_FLAGS, 8'h01, "receive flag");
        cei_host_model_inst.wr(CEI_ADDR_RR_HIGH, 8'hFF);
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        rdchk(CEI_ADDR_FLAGS, 8'h01, "receive flag cleared while ready");
        cei_host_model_inst.wr(CEI_ADDR_RR_HIGH, 8'h00);
        rdchk(CEI_ADDR_RR_HIGH, 8'h00, "ready clear");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        rdchk(CEI_ADDR_FLAGS, 8'h01, "receive flag cleared while low ready");
        cei_host_model_inst.wr(CEI_ADDR_RR_LOW, 8'h00);
        rdchk(CEI_ADDR_RR_LOW, 8'h00, "ready low clear");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        rdchk(CEI_ADDR_FLAGS, 8'h00, "receive flag clear");
        $display("t_rx done");
    endtask
    task automatic t_tchk();
        evt(6);
        txCheckEnable = 1'b1;
        repeat (3) evt(6);
        rdchk(CEI_ADDR_FLAGS, 8'h00, "check flag at 3");
        chk({7'h00, busOffRequest}, 8'h00, "bus-off request at 3");
        evt(6);
        rdchk(CEI_ADDR_FLAGS, 8'hA0, "check and bus-off flags at 4");
        chk({7'h00, busOffRequest}, 8'h01, "bus-off request at 4");
        @(negedge ref_clk) txCheckClear = 1'b1;
        @(negedge ref_clk) txCheckClear = 1'b0;
        cyc(1);
        chk({7'h00, busOffRequest}, 8'h00, "bus-off request after clear");
        txCheckEnable = 1'b0;
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        $display("t_tchk done");
    endtask
    task automatic t_hold();
        cei_host_model_inst.wr(CEI_ADDR_MASK, 8'h02);
        evt(1);
        wait_int();
        evt(7);
        evt(7);
        cyc(2);
        chk({7'h00, intOut}, 8'h01, "intOut dropped with flag set");
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        cyc(2);
        chk({7'h00, intOut}, 8'h00, "intOut held after clear");
        evt(1);
        wait_int();
        cei_host_model_inst.wr(CEI_ADDR_FLAGS, 8'h00);
        evt(7);
        cyc(2);
        chk({7'h00, intOut}, 8'h01, "intOut short after restart");
        evt(7);
        cyc(2);
        chk({7'h00, intOut}, 8'h00, "intOut after bit time");
        $display("t_hold done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        t_reset();
        t_events();
        t_levels();
        t_rx();
        t_tchk();
        t_hold();
        results();
    end
endmodule
